// ### logic/hamg_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "hamg_consts.vh"

module hamg_regs #(
  parameter integer NUM_RX_CHAN = 32,
  parameter integer NUM_GCI_ENTRY = 12,
  parameter integer MS_CYCLES = `HAMG_CLK_KHZ,
  parameter integer DESEL_MS = `HAMG_DESEL_MS
) (
  input wire clock_i,
  input wire reset_i,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // address field check from the receiver
  input wire rx_addr_valid_i,
  input wire [4:0] rx_addr_chan_i,
  input wire [7:0] rx_addr_first_i,
  input wire [7:0] rx_addr_second_i,
  output reg rx_addr_done_o,
  output reg rx_frame_accept_o,
  // transparent mode byte stream
  input wire rx_byte_valid_i,
  input wire [7:0] rx_byte_i,
  output reg rx_msg_end_o,
  output wire transparent_mode_one_o,
  // gci channel controls, entry index is channel * 2 + multiplex
  output wire [NUM_GCI_ENTRY-1:0] monitor_enable_o,
  output wire [NUM_GCI_ENTRY-1:0] monitor_vstar_o,
  output wire [NUM_GCI_ENTRY-1:0] ci_enable_o,
  output wire [NUM_GCI_ENTRY-1:0] ci_six_bit_o,
  output reg [NUM_GCI_ENTRY-1:0] monitor_chan_reset_o,
  output reg [NUM_GCI_ENTRY-1:0] ci_chan_init_o
);

  // ****************************************
  // register storage
  // ****************************************
  reg [15:0] acc_q;
  reg [15:0] data_q;
  reg [15:0] fill_q;
  reg [15:0] gci0_q;
  reg [15:0] gci1_q;
  reg [15:0] gci2_q;
  reg [15:0] rxcmd_q;
  reg [15:0] value_mem [0:NUM_RX_CHAN-1];
  reg [15:0] mask_mem [0:NUM_RX_CHAN-1];

  // ****************************************
  // write channel
  // ****************************************
  reg aw_held_q;
  reg [7:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write;
  wire [15:0] wr_lane_mask;
  wire [15:0] wr_val;
  reg wr_hit;

  assign s_axi_awready_o = !aw_held_q && !reset_i;
  assign s_axi_wready_o = !w_held_q && !reset_i;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_o;
  assign wr_lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_val = w_data_q[15:0];

  always @* begin
    case (aw_addr_q)
      {`HAMG_IDX_ACC, 2'b00},
      {`HAMG_IDX_DATA, 2'b00},
      {`HAMG_IDX_FILL, 2'b00},
      {`HAMG_IDX_GCI0, 2'b00},
      {`HAMG_IDX_GCI1, 2'b00},
      {`HAMG_IDX_GCI2, 2'b00},
      {`HAMG_IDX_RXCMD, 2'b00}: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `HAMG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `HAMG_RESP_OKAY : `HAMG_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // register writes and indirect access
  // ****************************************
  wire wr_acc;
  wire [15:0] acc_new;
  wire [4:0] acc_chan;
  wire acc_read;
  wire acc_mask;

  assign wr_acc = do_write && (aw_addr_q == {`HAMG_IDX_ACC, 2'b00}) && (w_strb_q[1:0] != 2'b00);
  assign acc_new = ((wr_val & wr_lane_mask) | (acc_q & ~wr_lane_mask)) & `HAMG_ACC_WMASK;
  assign acc_chan = acc_new[`HAMG_ACC_CH_HI:`HAMG_ACC_CH_LO];
  assign acc_read = acc_new[`HAMG_ACC_READ];
  assign acc_mask = acc_new[`HAMG_ACC_MASK];

  always @(posedge clock_i) begin
    if (reset_i) begin
      acc_q <= `HAMG_RST_ACC;
      data_q <= `HAMG_RST_DATA;
      fill_q <= `HAMG_RST_FILL;
      gci0_q <= `HAMG_RST_GCI;
      gci1_q <= `HAMG_RST_GCI;
      gci2_q <= `HAMG_RST_GCI;
      rxcmd_q <= `HAMG_RST_RXCMD;
    end else if (do_write) begin
      case (aw_addr_q)
        {`HAMG_IDX_ACC, 2'b00}: begin
          acc_q <= acc_new;
          if (acc_read && (w_strb_q[1:0] != 2'b00)) begin
            data_q <= acc_mask ? mask_mem[acc_chan] : value_mem[acc_chan];
          end
        end
        {`HAMG_IDX_DATA, 2'b00}: begin
          data_q <= (wr_val & wr_lane_mask) | (data_q & ~wr_lane_mask);
        end
        {`HAMG_IDX_FILL, 2'b00}: begin
          fill_q <= ((wr_val & wr_lane_mask) | (fill_q & ~wr_lane_mask)) & `HAMG_FILL_WMASK;
        end
        {`HAMG_IDX_GCI0, 2'b00}: begin
          gci0_q <= (wr_val & wr_lane_mask) | (gci0_q & ~wr_lane_mask);
        end
        {`HAMG_IDX_GCI1, 2'b00}: begin
          gci1_q <= (wr_val & wr_lane_mask) | (gci1_q & ~wr_lane_mask);
        end
        {`HAMG_IDX_GCI2, 2'b00}: begin
          gci2_q <= (wr_val & wr_lane_mask) | (gci2_q & ~wr_lane_mask);
        end
        {`HAMG_IDX_RXCMD, 2'b00}: begin
          rxcmd_q <= ((wr_val & wr_lane_mask) | (rxcmd_q & ~wr_lane_mask)) & `HAMG_RXCMD_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // recognition memories hold no reset; software loads them before enabling checks
  always @(posedge clock_i) begin
    if (wr_acc && !acc_read) begin
      if (acc_mask) begin
        mask_mem[acc_chan] <= data_q;
      end else begin
        value_mem[acc_chan] <= data_q;
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  reg [15:0] rd_val;
  reg rd_hit;

  assign s_axi_arready_o = !s_axi_rvalid_o && !reset_i;

  always @* begin
    rd_hit = 1'b1;
    case ({s_axi_araddr_i[7:2], 2'b00})
      {`HAMG_IDX_ACC, 2'b00}: begin
        rd_val = acc_q;
      end
      {`HAMG_IDX_DATA, 2'b00}: begin
        rd_val = data_q;
      end
      {`HAMG_IDX_FILL, 2'b00}: begin
        rd_val = fill_q;
      end
      {`HAMG_IDX_GCI0, 2'b00}: begin
        rd_val = gci0_q;
      end
      {`HAMG_IDX_GCI1, 2'b00}: begin
        rd_val = gci1_q;
      end
      {`HAMG_IDX_GCI2, 2'b00}: begin
        rd_val = gci2_q;
      end
      {`HAMG_IDX_RXCMD, 2'b00}: begin
        rd_val = rxcmd_q;
      end
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `HAMG_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {16'h0000, rd_val};
      s_axi_rresp_o <= rd_hit ? `HAMG_RESP_OKAY : `HAMG_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // address field match
  // ****************************************
  wire [15:0] chk_val;
  wire [15:0] chk_mask;
  wire first_ok;
  wire second_ok;

  assign chk_val = value_mem[rx_addr_chan_i];
  assign chk_mask = mask_mem[rx_addr_chan_i];
  assign first_ok = !rxcmd_q[`HAMG_RXCMD_FIRST] || (((rx_addr_first_i ^ chk_val[7:0]) & ~chk_mask[7:0]) == 8'h00);
  assign second_ok = !rxcmd_q[`HAMG_RXCMD_SECOND] ||
    (((rx_addr_second_i ^ chk_val[15:8]) & ~chk_mask[15:8]) == 8'h00);

  always @(posedge clock_i) begin
    if (reset_i) begin
      rx_addr_done_o <= 1'b0;
      rx_frame_accept_o <= 1'b0;
    end else begin
      rx_addr_done_o <= rx_addr_valid_i;
      if (rx_addr_valid_i) begin
        rx_frame_accept_o <= first_ok && second_ok;
      end
    end
  end

  // ****************************************
  // transparent mode fill character
  // ****************************************
  assign transparent_mode_one_o = rxcmd_q[`HAMG_RXCMD_TRANSP1];

  always @(posedge clock_i) begin
    if (reset_i) begin
      rx_msg_end_o <= 1'b0;
    end else begin
      rx_msg_end_o <= transparent_mode_one_o && rx_byte_valid_i && (rx_byte_i == fill_q[7:0]);
    end
  end

  // ****************************************
  // millisecond enable
  // ****************************************
  reg [31:0] ms_cnt_q;
  reg ms_tick_q;

  always @(posedge clock_i) begin
    if (reset_i) begin
      ms_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q == MS_CYCLES - 1) begin
      ms_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

  // ****************************************
  // gci channel definitions
  // ****************************************
  wire [47:0] gci_all;
  // entry is channel * 2 + multiplex
  assign gci_all = {gci2_q, gci1_q, gci0_q};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GCI_ENTRY; gi = gi + 1) begin : g_entry
      wire [3:0] nib;
      reg [7:0] mon_ms_q;
      reg [7:0] ci_ms_q;
      assign nib = gci_all[4*gi+3:4*gi];
      assign monitor_enable_o[gi] = nib[`HAMG_NIB_MON_VALID];
      assign monitor_vstar_o[gi] = nib[`HAMG_NIB_MON_VALID] & nib[`HAMG_NIB_MON_PROTO];
      assign ci_enable_o[gi] = nib[`HAMG_NIB_CI_VALID];
      assign ci_six_bit_o[gi] = nib[`HAMG_NIB_CI_VALID] & nib[`HAMG_NIB_CI_WIDTH];

      // first tick may be partial, so one extra tick guarantees the full period
      always @(posedge clock_i) begin
        if (reset_i) begin
          mon_ms_q <= 8'h00;
          ci_ms_q <= 8'h00;
          monitor_chan_reset_o[gi] <= 1'b0;
          ci_chan_init_o[gi] <= 1'b0;
        end else begin
          monitor_chan_reset_o[gi] <= 1'b0;
          ci_chan_init_o[gi] <= 1'b0;
          if (nib[`HAMG_NIB_MON_VALID]) begin
            mon_ms_q <= 8'h00;
          end else if (ms_tick_q && (mon_ms_q != DESEL_MS[7:0] + 8'h01)) begin
            mon_ms_q <= mon_ms_q + 8'h01;
            monitor_chan_reset_o[gi] <= (mon_ms_q == DESEL_MS[7:0]);
          end
          if (nib[`HAMG_NIB_CI_VALID]) begin
            ci_ms_q <= 8'h00;
          end else if (ms_tick_q && (ci_ms_q != DESEL_MS[7:0] + 8'h01)) begin
            ci_ms_q <= ci_ms_q + 8'h01;
            ci_chan_init_o[gi] <= (ci_ms_q == DESEL_MS[7:0]);
          end
        end
      end
    end
  endgenerate

endmodule // hamg_regs
`default_nettype wire

// ### logic/hamg_consts.vh
// Function
// - writing the access address register starts the indirect memory read or write.
// - mask select 1 reaches the mask memory, 0 the value memory.
// - direction bit 1 reads the selected entry, 0 writes it.
// - five-bit channel field picks one of 32 receive channels.
// - data register low byte is first address byte, high byte second.
// - first byte compared only where mask bit is 0; mismatch ignores frame.
// - second byte compared only where mask bit is 0; mismatch discards frame.
// - with mask select set, both data bytes store as the channel mask.
// - first and second byte enables gate each check; both off accepts all.
// - in transparent mode one a single fill character ends a message.
// - definition entries indexed by channel 0 to 5 and multiplex 0 or 1.
// - nibbles hold width, c/i valid, protocol, monitor valid from msb down.
// - monitor valid 1 enables the monitor channel, 0 disables it.
// - monitor valid held 0 for 125 ms resets that monitor channel.
// - protocol bit 1 selects star variant, 0 standard monitor protocol.
// - c/i valid 1 enables the command/indicate channel, 0 disables it.
// - c/i valid held 0 for 125 ms completes channel initialisation.
// - width bit 1 gives six-bit primitives, 0 four-bit primitives.
`ifndef HAMG_CONSTS_VH
`define HAMG_CONSTS_VH

// register indices; byte address is four times the index
`define HAMG_IDX_ACC 6'h1c
`define HAMG_IDX_DATA 6'h1e
`define HAMG_IDX_FILL 6'h20
`define HAMG_IDX_GCI0 6'h22
`define HAMG_IDX_GCI1 6'h24
`define HAMG_IDX_GCI2 6'h26
`define HAMG_IDX_RXCMD 6'h30

// reset values
`define HAMG_RST_ACC 16'h0000
`define HAMG_RST_DATA 16'h0001
`define HAMG_RST_FILL 16'h0000
`define HAMG_RST_GCI 16'h0000
`define HAMG_RST_RXCMD 16'h0000

// access address register fields
`define HAMG_ACC_CH_HI 15
`define HAMG_ACC_CH_LO 11
`define HAMG_ACC_READ 10
`define HAMG_ACC_MASK 9
`define HAMG_ACC_WMASK 16'hfe00

// own receive command register fields
`define HAMG_RXCMD_FIRST 0
`define HAMG_RXCMD_SECOND 1
`define HAMG_RXCMD_TRANSP1 2
`define HAMG_RXCMD_WMASK 16'h0007

// fill character field
`define HAMG_FILL_WMASK 16'h00ff

// definition nibble fields
`define HAMG_NIB_MON_VALID 0
`define HAMG_NIB_MON_PROTO 1
`define HAMG_NIB_CI_VALID 2
`define HAMG_NIB_CI_WIDTH 3

// timing
`define HAMG_DESEL_MS 125
`define HAMG_CLK_KHZ 50000

// axi responses
`define HAMG_RESP_OKAY 2'b00
`define HAMG_RESP_SLVERR 2'b10

`endif

// ### dv/hamg_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checker
// ********
module hamg_chk #(
  parameter integer NUM_GCI_ENTRY = 12
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic rx_addr_valid_i,
  input wire logic rx_addr_done_o,
  input wire logic rx_byte_valid_i,
  input wire logic rx_msg_end_o,
  input wire logic transparent_mode_one_o,
  input wire logic [NUM_GCI_ENTRY-1:0] monitor_enable_o,
  input wire logic [NUM_GCI_ENTRY-1:0] monitor_vstar_o,
  input wire logic [NUM_GCI_ENTRY-1:0] ci_enable_o,
  input wire logic [NUM_GCI_ENTRY-1:0] ci_six_bit_o,
  input wire logic [NUM_GCI_ENTRY-1:0] monitor_chan_reset_o,
  input wire logic [NUM_GCI_ENTRY-1:0] ci_chan_init_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid_o)
    else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  check_done_a: assert property (rx_addr_valid_i |=> rx_addr_done_o)
    else $error("address check not done");
  done_cause_a: assert property (rx_addr_done_o |-> $past(rx_addr_valid_i))
    else $error("spurious check done");
  msg_end_a: assert property (rx_msg_end_o |-> $past(rx_byte_valid_i) && $past(transparent_mode_one_o))
    else $error("message end without fill byte");
  vstar_gate_a: assert property ((monitor_vstar_o & ~monitor_enable_o) == '0)
    else $error("protocol select without monitor valid");
  six_gate_a: assert property ((ci_six_bit_o & ~ci_enable_o) == '0)
    else $error("width select without c/i valid");
  mon_reset_a: assert property ((monitor_chan_reset_o & (monitor_enable_o | $past(monitor_chan_reset_o))) == '0)
    else $error("bad monitor reset pulse");
  ci_init_a: assert property ((ci_chan_init_o & (ci_enable_o | $past(ci_chan_init_o))) == '0)
    else $error("bad c/i init pulse");
endmodule // hamg_chk

bind hamg_regs hamg_chk #(.NUM_GCI_ENTRY(NUM_GCI_ENTRY)) chk_i (.*);
`default_nettype wire

// ### dv/test_hdlc_addr_match_gci_chan_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "hamg_consts.vh"
module test_hdlc_addr_match_gci_chan_cfg;
  localparam int MSC = 4;
  localparam int DMS = 3;
  localparam logic [7:0] A_ACC = 8'(`HAMG_IDX_ACC * 4);
  localparam logic [7:0] A_DATA = 8'(`HAMG_IDX_DATA * 4);
  localparam logic [7:0] A_FILL = 8'(`HAMG_IDX_FILL * 4);
  localparam logic [7:0] A_CMD = 8'(`HAMG_IDX_RXCMD * 4);
  localparam logic [1:0] OK = `HAMG_RESP_OKAY;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, rx_addr_first_i = '0, rx_addr_second_i = '0, rx_byte_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = 4'h3;
  logic [4:0] rx_addr_chan_i = '0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic rx_addr_valid_i = 0, rx_byte_valid_i = 0;
  wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire logic [31:0] s_axi_rdata_o;
  wire logic rx_addr_done_o, rx_frame_accept_o, rx_msg_end_o, transparent_mode_one_o;
  wire logic [11:0] monitor_enable_o, monitor_vstar_o, ci_enable_o, ci_six_bit_o, monitor_chan_reset_o, ci_chan_init_o;
  int err_total = 0;
  int samples_checked = 0;
  hamg_regs #(.MS_CYCLES(MSC), .DESEL_MS(DMS)) uut (.*);
  always #10 clock_i = ~clock_i;
  // ********
  // bus and compare tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = OK, input int lag = 0);
    @(posedge clock_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_awvalid_i && !s_axi_awready_o || s_axi_wvalid_i && !s_axi_wready_o);
    repeat (lag) @(posedge clock_i);
    s_axi_bready_i <= 1'b1;
    do @(posedge clock_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    chk(32'(s_axi_bresp_o), 32'(er));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er = OK, input int lag = 0);
    @(posedge clock_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(posedge clock_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    repeat (lag) @(posedge clock_i);
    s_axi_rready_i <= 1'b1;
    do @(posedge clock_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk(s_axi_rdata_o, {16'h0000, exp});
    chk(32'(s_axi_rresp_o), 32'(er));
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    for (int k = 0; k < 3; k++) rchk(8'(`HAMG_IDX_GCI0 * 4 + k * 8), `HAMG_RST_GCI);
    rchk(A_ACC, `HAMG_RST_ACC);
    rchk(A_DATA, `HAMG_RST_DATA);
    // low lane only: high byte keeps its reset value
    @(posedge clock_i);
    s_axi_wstrb_i <= 4'h1;
    wr(A_DATA, 16'hffff);
    s_axi_wstrb_i <= 4'h3;
    rchk(A_DATA, 16'h00ff);
    rchk(A_FILL, `HAMG_RST_FILL);
    rchk(A_CMD, `HAMG_RST_RXCMD);
    // late ready exercises the response hold checks
    wr(A_FILL, 16'hffff, OK, 2);
    rchk(A_FILL, 16'h00ff, OK, 2);
    wr(A_CMD, 16'hffff);
    rchk(A_CMD, 16'h0007);
    wr(8'h04, 16'h1234, `HAMG_RESP_SLVERR);
    rchk(8'h04, 16'h0000, `HAMG_RESP_SLVERR);
  endtask
  task automatic store(input logic [4:0] c, input logic [15:0] v, input logic [15:0] m);
    wr(A_DATA, v);
    wr(A_ACC, {c, 2'b00, 9'h000});
    wr(A_DATA, m);
    wr(A_ACC, {c, 2'b01, 9'h000});
  endtask
  task automatic fetch(input logic [4:0] c, input logic [15:0] v, input logic [15:0] m);
    wr(A_DATA, 16'h0000);
    wr(A_ACC, {c, 2'b10, 9'h1ff});
    rchk(A_ACC, {c, 2'b10, 9'h000});
    rchk(A_DATA, v);
    wr(A_ACC, {c, 2'b11, 9'h000});
    rchk(A_DATA, m);
  endtask
  task automatic t_match();
    logic [31:0] tb[8] = '{32'h05_0_00_00_1, 32'h05_1_3a_00_1, 32'h05_1_5b_a5_0, 32'h05_2_00_a3_1,
                           32'h05_2_5a_b5_0, 32'h05_3_fa_af_1, 32'h05_3_fa_95_0, 32'h1f_3_00_00_1};
    foreach (tb[i]) begin
      wr(A_CMD, {12'h000, tb[i][23:20]});
      @(posedge clock_i);
      rx_addr_valid_i <= 1'b1;
      rx_addr_chan_i <= tb[i][28:24];
      rx_addr_first_i <= tb[i][19:12];
      rx_addr_second_i <= tb[i][11:4];
      @(posedge clock_i);
      rx_addr_valid_i <= 1'b0;
      @(posedge clock_i);
      chk(32'(rx_addr_done_o), 32'h1);
      chk(32'(rx_frame_accept_o), 32'(tb[i][0]));
    end
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    @(posedge clock_i);
    rx_byte_valid_i <= 1'b1;
    rx_byte_i <= b;
    @(posedge clock_i);
    rx_byte_valid_i <= 1'b0;
    @(posedge clock_i);
    chk(32'(rx_msg_end_o), 32'(e));
  endtask
  task automatic t_fill();
    wr(A_FILL, 16'h007e);
    wr(A_CMD, 16'h0004);
    chk(32'(transparent_mode_one_o), 32'h1);
    send(8'h7e, 1'b1);
    send(8'h55, 1'b0);
    wr(A_CMD, 16'h0000);
    send(8'h7e, 1'b0);
  endtask
  task automatic t_gci();
    logic [15:0] w[3] = '{16'hf3c1, 16'h2a85, 16'h0e7d};
    logic [3:0] nb;
    for (int k = 0; k < 3; k++) wr(8'(`HAMG_IDX_GCI0 * 4 + k * 8), w[k]);
    for (int k = 0; k < 3; k++) rchk(8'(`HAMG_IDX_GCI0 * 4 + k * 8), w[k]);
    for (int e = 0; e < 12; e++) begin
      nb = w[e / 4][(e % 4) * 4 +: 4];
      chk({ci_six_bit_o[e], ci_enable_o[e], monitor_vstar_o[e], monitor_enable_o[e]},
          {nb[3] & nb[2], nb[2], nb[1] & nb[0], nb[0]});
    end
  endtask
  task automatic t_desel();
    int n = 0;
    int p = 0;
    wr(8'(`HAMG_IDX_GCI0 * 4), 16'h0005);
    wr(8'(`HAMG_IDX_GCI0 * 4), 16'h0000);
    while (!monitor_chan_reset_o[0] && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(n >= DMS * MSC - 2 && n <= (DMS + 1) * MSC + 1), 32'h1);
    chk(32'(ci_chan_init_o[0]), 32'h1);
    repeat (40) begin
      @(posedge clock_i);
      p += monitor_chan_reset_o[0] + ci_chan_init_o[0];
    end
    chk(32'(p), 32'h0);
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    store(5'd5, 16'ha55a, 16'h0ff0);
    store(5'd31, 16'h3cc3, 16'hffff);
    fetch(5'd5, 16'ha55a, 16'h0ff0);
    fetch(5'd31, 16'h3cc3, 16'hffff);
    t_match();
    t_fill();
    t_gci();
    t_desel();
    wrap_up();
  end
endmodule // test_hdlc_addr_match_gci_chan_cfg
`default_nettype wire
